// [inc/pplg_pkg.sv]
// Package of constants and carrier types for the two-port pin logic block
// Function
// - Each bus port pin is pulled low by a 0 latch bit, released by a 1.
// - A bus port pin with latch 1 floats and reads the external level.
// - During data accesses the bus port carries low address, then data.
// - As the memory bus the bus port drives ones high actively.
// - Input port pins are input-only; latch writes only pick the function.
// - After reset every input port pin is analog, its digital path off.
// - Latch 0 makes an input pin digital and readable; 1 keeps it analog.
// - Analog input pins feed the converter on the channel picked by control.
// - Input port bit 1 is the counter 2 capture or reload trigger when digital.
// - Input port bit 1 is also the counter 2 up/down control in that mode; no up/down output is provided.
// - Third port drives middle then high address byte during data accesses.
package pplg_pkg;
  localparam int          PORT_W       = 8;
  localparam int          CH_W         = 3;
  localparam logic [7:0]  BUS_LATCH_RST = 8'hFF;
  localparam logic [7:0]  IN_LATCH_RST  = 8'hFF;
  localparam logic [7:0]  ADDR_PORT_RST = 8'hFF;
  localparam logic [CH_W-1:0] CH_RST    = 3'h0;

  // Access sequence; Gray coded from IDLE to DONE, two bits flip on the return to IDLE
  typedef enum logic [2:0] {
    PPLG_IDLE  = 3'b000,
    PPLG_ADDR  = 3'b001,
    PPLG_PAGE  = 3'b011,
    PPLG_DATA  = 3'b010,
    PPLG_DONE  = 3'b110
  } pplg_state_t;

  typedef struct packed {
    logic        req;
    logic        wr;
    logic [23:0] addr;
    logic [7:0]  wdata;
  } pplg_xreq_t;

  typedef struct packed {
    logic [7:0] o;
    logic [7:0] oe;
  } pplg_pin_t;
endpackage

// [src/pplg_input_port.sv]
// Input-only port: analog/digital selection per pin and counter 2 feed
`timescale 1ns/1ps
module pplg_input_port (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic                      ce,
  input  wire logic                      latch_we,
  input  wire logic [pplg_pkg::PORT_W-1:0] latch_wdata,
  input  wire logic [pplg_pkg::PORT_W-1:0] pin_i,
  input  wire logic [pplg_pkg::CH_W-1:0]   ch_sel,
  output logic      [pplg_pkg::PORT_W-1:0] latch_q,
  output logic      [pplg_pkg::PORT_W-1:0] rd_q,
  output logic      [pplg_pkg::PORT_W-1:0] analog_en_q,
  output logic                           analog_in_ch1_sel_q,
  output logic                           counter2_trigger_in_q
);
  import pplg_pkg::*;

  // Latch never drives the pin; it only picks analog or digital
  always_ff @(posedge clk) begin
    if (rst) begin
      latch_q <= IN_LATCH_RST;
    end else if (ce && latch_we) begin
      latch_q <= latch_wdata;
    end
  end

  genvar g;
  generate
    for (g = 0; g < PORT_W; g++) begin : g_bit
      always_ff @(posedge clk) begin
        if (rst) begin
          rd_q[g]        <= 1'b0;
          analog_en_q[g] <= 1'b0;
        end else if (ce) begin
          // Digital path gated off in analog mode, reads as zero
          rd_q[g] <= ~latch_q[g] & pin_i[g];
          // Only the selected channel connects to the converter
          analog_en_q[g] <= latch_q[g] &&
                            (ch_sel == CH_W'(g));
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (rst) begin
      counter2_trigger_in_q <= 1'b0;
      analog_in_ch1_sel_q   <= 1'b0;
    end else if (ce) begin
      // Digital level of bit 1 serves as the counter 2 trigger; there is no up/down output
      counter2_trigger_in_q <= ~latch_q[1] & pin_i[1];
      analog_in_ch1_sel_q   <= latch_q[1] && (ch_sel == 3'h1);
    end
  end
endmodule

// [src/pplg_top.sv]
// Bus port, address port and input port pin logic
`timescale 1ns/1ps
module pplg_top (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic                      ce,
  input  wire logic                      bus_latch_we,
  input  wire logic [7:0]                bus_latch_wdata,
  input  wire logic                      addr_latch_we,
  input  wire logic [7:0]                addr_latch_wdata,
  input  wire logic                      in_latch_we,
  input  wire logic [7:0]                in_latch_wdata,
  input  wire logic [pplg_pkg::CH_W-1:0]   converter_channel_ctrl,
  input  wire pplg_pkg::pplg_xreq_t      xreq,
  input  wire logic [7:0]                bus_pin_i,
  input  wire logic [7:0]                addr_pin_i,
  input  wire logic [7:0]                in_pin_i,
  output pplg_pkg::pplg_pin_t            bus_pin,
  output pplg_pkg::pplg_pin_t            addr_pin,
  output logic                           addr_strobe,
  output logic                           rd_strobe_n,
  output logic                           wr_strobe_n,
  output logic                           xbusy,
  output logic                           xdone,
  output logic [7:0]                     xrdata,
  output logic [7:0]                     bus_rd,
  output logic [7:0]                     addr_rd,
  output logic [7:0]                     bus_latch,
  output logic [7:0]                     in_latch,
  output logic [7:0]                     in_rd,
  output logic [7:0]                     analog_en,
  output logic                           analog_in_ch1_sel,
  output logic                           counter2_trigger_in
);
  import pplg_pkg::*;

  pplg_state_t state_r;
  pplg_state_t state_nxt;
  pplg_xreq_t  req_r;
  logic [7:0]  bus_latch_r;
  logic [7:0]  addr_latch_r;

  // Sequence: low+middle address, page on third port, data, release
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      PPLG_IDLE: begin
        if (xreq.req) begin
          state_nxt = PPLG_ADDR;
        end
      end
      PPLG_ADDR: begin
        state_nxt = PPLG_PAGE;
      end
      PPLG_PAGE: begin
        state_nxt = PPLG_DATA;
      end
      PPLG_DATA: begin
        state_nxt = PPLG_DONE;
      end
      PPLG_DONE: begin
        state_nxt = PPLG_IDLE;
      end
      default: begin
        state_nxt = PPLG_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= PPLG_IDLE;
    end else if (ce) begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      req_r <= '0;
    end else if (ce && state_r == PPLG_IDLE && xreq.req) begin
      req_r <= xreq;
    end
  end

  // Latch written only by the core; bus traffic never touches it
  always_ff @(posedge clk) begin
    if (rst) begin
      bus_latch_r  <= BUS_LATCH_RST;
      addr_latch_r <= ADDR_PORT_RST;
    end else if (ce) begin
      if (bus_latch_we) begin
        bus_latch_r <= bus_latch_wdata;
      end
      if (addr_latch_we) begin
        addr_latch_r <= addr_latch_wdata;
      end
    end
  end

  // Pin drive: open drain in port mode, push-pull as memory bus
  always_ff @(posedge clk) begin
    if (rst) begin
      bus_pin.o  <= 8'h00;
      bus_pin.oe <= 8'h00;
      addr_pin.o  <= 8'h00;
      addr_pin.oe <= 8'h00;
    end else if (ce) begin
      case (state_nxt)
        PPLG_ADDR: begin
          bus_pin.o   <= req_nxt_addr(state_r, xreq, req_r, 0);
          bus_pin.oe  <= 8'hFF;
          addr_pin.o  <= req_nxt_addr(state_r, xreq, req_r, 1);
          addr_pin.oe <= 8'hFF;
        end
        PPLG_PAGE: begin
          bus_pin.o   <= req_r.addr[7:0];
          bus_pin.oe  <= 8'hFF;
          addr_pin.o  <= req_r.addr[23:16];
          addr_pin.oe <= 8'hFF;
        end
        PPLG_DATA, PPLG_DONE: begin
          // Reads release the bus so the memory can drive it
          bus_pin.o   <= req_r.wdata;
          bus_pin.oe  <= {8{req_r.wr}};
          addr_pin.o  <= req_r.addr[23:16];
          addr_pin.oe <= 8'hFF;
        end
        default: begin
          // Latch returns to the pins once the access ends
          bus_pin.o   <= 8'h00;
          bus_pin.oe  <= ~bus_latch_r;
          addr_pin.o  <= 8'h00;
          addr_pin.oe <= ~addr_latch_r;
        end
      endcase
    end
  end

  function automatic logic [7:0] req_nxt_addr(
    input pplg_state_t s,
    input pplg_xreq_t  n,
    input pplg_xreq_t  r,
    input int          sel
  );
    logic [23:0] a;
    a = (s == PPLG_IDLE) ? n.addr : r.addr;
    return (sel == 0) ? a[7:0] : a[15:8];
  endfunction

  // Strobes; the low address byte stays on the bus while strobe is high
  always_ff @(posedge clk) begin
    if (rst) begin
      addr_strobe <= 1'b0;
      rd_strobe_n <= 1'b1;
      wr_strobe_n <= 1'b1;
    end else if (ce) begin
      addr_strobe <= (state_nxt == PPLG_ADDR) ||
                     (state_nxt == PPLG_PAGE);
      rd_strobe_n <= !((state_nxt == PPLG_DATA) && !req_r.wr);
      wr_strobe_n <= !((state_nxt == PPLG_DATA) && req_r.wr);
    end
  end

  // Results and read-back of the pins
  always_ff @(posedge clk) begin
    if (rst) begin
      xbusy  <= 1'b0;
      xdone  <= 1'b0;
      xrdata <= 8'h00;
      bus_rd <= 8'h00;
      addr_rd <= 8'h00;
      bus_latch <= BUS_LATCH_RST;
    end else if (ce) begin
      xbusy <= (state_nxt != PPLG_IDLE);
      xdone <= (state_r == PPLG_DONE);
      if (state_r == PPLG_DATA && !req_r.wr) begin
        xrdata <= bus_pin_i;
      end
      bus_rd  <= bus_pin_i;
      addr_rd <= addr_pin_i;
      bus_latch <= bus_latch_r;
    end
  end

  pplg_input_port u_in (
    .clk                   (clk),
    .rst                   (rst),
    .ce                    (ce),
    .latch_we              (in_latch_we),
    .latch_wdata           (in_latch_wdata),
    .pin_i                 (in_pin_i),
    .ch_sel                (converter_channel_ctrl),
    .latch_q               (in_latch),
    .rd_q                  (in_rd),
    .analog_en_q           (analog_en),
    .analog_in_ch1_sel_q   (analog_in_ch1_sel),
    .counter2_trigger_in_q (counter2_trigger_in)
  );
endmodule

// [tb/pplg_top_properties.sv]
// Checker for the pin logic top ports
`timescale 1ns/1ps
module pplg_checker
  import pplg_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       ce,
  input wire pplg_pin_t  bus_pin,
  input wire logic [7:0] bus_pin_i,
  input wire logic [7:0] bus_latch,
  input wire logic [7:0] bus_rd,
  input wire logic       addr_strobe,
  input wire logic       rd_strobe_n,
  input wire logic       wr_strobe_n,
  input wire logic       xbusy,
  input wire logic [7:0] in_pin_i,
  input wire logic [7:0] in_latch,
  input wire logic [7:0] in_rd,
  input wire logic [7:0] analog_en,
  input wire logic [2:0] converter_channel_ctrl,
  input wire logic       counter2_trigger_in
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_port_low: assert property (!xbusy |-> bus_pin.o == 8'h00)
    else $error("port drives high");
  a_port_release: assert property (!xbusy && $stable(bus_latch)
    |-> bus_pin.oe == ~bus_latch) else $error("port enable");
  a_float_read: assert property (ce |=> bus_rd == $past(bus_pin_i))
    else $error("pin read");
  // Assumes ce stays high through an access
  a_addr_data: assert property ($rose(addr_strobe) |-> ##2
    (!addr_strobe && rd_strobe_n != wr_strobe_n)) else $error("phases");
  a_bus_strong: assert property ((addr_strobe || !wr_strobe_n)
    |-> bus_pin.oe == 8'hFF) else $error("bus drive");
  a_digital_read: assert property (ce |=>
    in_rd == ($past(in_pin_i) & ~$past(in_latch))) else $error("in read");
  a_channel_pick: assert property (ce |=> analog_en ==
    ($past(in_latch) & (8'h01 << $past(converter_channel_ctrl))))
    else $error("channel");
  a_trigger_feed: assert property (ce |=> counter2_trigger_in ==
    ($past(in_pin_i[1]) & ~$past(in_latch[1]))) else $error("trigger");
  c_write: cover property (!wr_strobe_n);
  c_read: cover property (!rd_strobe_n);
  c_digital: cover property (in_rd[1]);
endmodule
bind pplg_top pplg_checker chk (.clk, .rst, .ce, .bus_pin, .bus_pin_i,
  .bus_latch, .bus_rd, .addr_strobe, .rd_strobe_n, .wr_strobe_n, .xbusy,
  .in_pin_i, .in_latch, .in_rd, .analog_en, .converter_channel_ctrl,
  .counter2_trigger_in);

// [tb/pplg_mem_model.sv]
// External data memory on the multiplexed bus
`timescale 1ns/1ps
module pplg_mem_model
  import pplg_pkg::*;
(
  input  wire logic      clk,
  input  wire pplg_pin_t bus_pin,
  input  wire pplg_pin_t addr_pin,
  input  wire logic      addr_strobe,
  input  wire logic      rd_strobe_n,
  input  wire logic      wr_strobe_n,
  output logic           drv_en,
  output logic [7:0]     drv_d,
  output logic [23:0]    addr_q
);
  logic [7:0] mem [256];
  logic       ph2_r = 1'b0;
  // Low byte alone indexes storage; upper bytes kept for checking
  always @(posedge clk) begin
    if (addr_strobe && !ph2_r) begin
      addr_q[15:0] <= {addr_pin.o, bus_pin.o};
    end
    if (addr_strobe && ph2_r) begin
      addr_q[23:16] <= addr_pin.o;
    end
    ph2_r <= addr_strobe;
    if (!wr_strobe_n) mem[addr_q[7:0]] <= bus_pin.o;
  end
  assign drv_en = !rd_strobe_n;
  assign drv_d  = mem[addr_q[7:0]];
endmodule

// [tb/port0_port1_pin_logic_bench.sv]
// Self-checking bench for the two-port pin logic
`timescale 1ns/1ps
module port0_port1_pin_logic_bench;
  import pplg_pkg::*;
  logic       clk, rst, ce, bw, aw, iw, astb, rdn, wrn, busy, done;
  logic       ch1, trig, m_en;
  logic [7:0] bd, ad, id, bpi, api, ipi, xrd, brd, ard, bl, il, ird;
  logic [7:0] aen, ext, m_d;
  logic [2:0] ch;
  logic [23:0] m_a;
  pplg_xreq_t xreq;
  pplg_pin_t  bp, ap;
  int         num_errors, num_checks;
  // Released bus pins show the board level, not the last driven value
  assign bpi = (bp.oe & bp.o) | (~bp.oe & (m_en ? m_d : ext));
  assign api = (ap.oe & ap.o) | (~ap.oe & ~ext);
  pplg_top dut (.clk(clk), .rst(rst), .ce(ce), .bus_latch_we(bw),
    .bus_latch_wdata(bd), .addr_latch_we(aw), .addr_latch_wdata(ad),
    .in_latch_we(iw), .in_latch_wdata(id), .converter_channel_ctrl(ch),
    .xreq(xreq), .bus_pin_i(bpi), .addr_pin_i(api), .in_pin_i(ipi),
    .bus_pin(bp), .addr_pin(ap), .addr_strobe(astb), .rd_strobe_n(rdn),
    .wr_strobe_n(wrn), .xbusy(busy), .xdone(done), .xrdata(xrd),
    .bus_rd(brd), .addr_rd(ard), .bus_latch(bl), .in_latch(il),
    .in_rd(ird), .analog_en(aen), .analog_in_ch1_sel(ch1),
    .counter2_trigger_in(trig));
  pplg_mem_model mem (.clk(clk), .bus_pin(bp), .addr_pin(ap),
    .addr_strobe(astb), .rd_strobe_n(rdn), .wr_strobe_n(wrn),
    .drv_en(m_en), .drv_d(m_d), .addr_q(m_a));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input string w, input logic [23:0] s, e);
    num_checks++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", w, e, s);
    end
  endtask
  task automatic step(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic access(input logic w, input logic [23:0] a, d);
    int n;
    xreq = '{1'b1, w, a, d[7:0]};
    step();
    xreq.req = 1'b0;
    chk("busy", busy, 1'b1);
    chk("addr low", bp.o, a[7:0]);
    chk("addr mid", ap.o, a[15:8]);
    for (n = 0; n < 10 && done !== 1'b1; n++) step();
    chk("done", done, 1'b1);
    if (done !== 1'b1) complete_run();
  endtask
  task automatic t_port;
    bw = 1'b1;
    bd = 8'h5A;
    aw = 1'b1;
    ad = 8'h0F;
    step();
    {bw, aw} = 2'b00;
    // Latch, then pins, then registered pin read: three edges
    step(3);
    chk("oe", bp.oe, 8'hA5);
    chk("addr oe", ap.oe, 8'hF0);
    chk("read", brd, 8'h42);
    chk("addr read", ard, 8'h0C);
    {ce, bw, bd} = {2'b01, 8'h00};
    step();
    {ce, bw} = 2'b10;
    chk("freeze", bl, 8'h5A);
    $display("port test done");
  endtask
  task automatic t_mem;
    access(1'b1, 24'h3C8142, 8'hA5);
    chk("mem addr", m_a, 24'h3C8142);
    access(1'b0, 24'h3C8142, 8'h00);
    chk("rdata", xrd, 8'hA5);
    step();
    chk("latch", bl, 8'h5A);
    chk("restore", bp.oe, 8'hA5);
    $display("memory test done");
  endtask
  task automatic t_input;
    chk("reset", il, 8'hFF);
    {iw, id, ipi} = {1'b1, 16'hFDFF};
    step();
    iw = 1'b0;
    step(2);
    chk("digital", ird, 8'h02);
    chk("trig hi", trig, 1'b1);
    ipi = 8'h00;
    step(2);
    chk("trig lo", trig, 1'b0);
    {iw, id, ch} = {1'b1, 8'hFF, 3'h1};
    step();
    iw = 1'b0;
    step(2);
    chk("ch1", ch1, 1'b1);
    chk("analog", aen, 8'h02);
    $display("input test done");
  endtask
  initial begin
    {rst, ce, bw, aw, iw, bd, ad, id, ipi, ch} = {2'b11, 38'h0};
    xreq = '0;
    num_errors = 0;
    num_checks = 0;
    ext = 8'hC3;
    step(2);
    rst = 1'b0;
    chk("reset oe", bp.oe, 8'h00);
    t_input();
    t_port();
    t_mem();
    complete_run();
  end
endmodule
